/* design/capture_pin_control.sv */
// Pin control: clamp, sample clock, hold, power-down, syncs, address strap
//
// Behaviour
// - Clamp source bit set selects the external clamp input; resets to zero.
// - Clamp source clear: ignore pin, count delay then duration from line sync trailing edge.
// - Clamp input active level is auto-detected or set by the shared polarity field.
// - Clock source bit set selects the external sample clock over the PLL clock.
// - Shared pin serves external clock and hold together, neither altering the other.
// - Active hold stops line sync tracking; clock keeps its frequency and phase.
// - Hold active level auto-detected or manual; defaults to active high after reset.
// - Power-down: bit 4 manual select, bit 3 command with pin, bit 2 pin polarity.
// - Regenerated line sync aligned with input, programmable polarity and width.
// - Frame sync out is separated or passed-through frame sync, polarity by register.
// - Frame sync out width follows the source or the width register.
// - Address strap sampled at power-up gives the serial address LSB.
// - Leading line sync edge tracks the PLL, trailing edge times the clamp.
// - Frame sync input active level auto-detected or set by its polarity field.
`timescale 1ns/1ps
module capture_pin_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access from the serial control port
  input wire logic regWe,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Pins from outside the clock domain
  input wire logic clampPin,
  input wire logic extClockCoastPin,
  input wire logic power_down_pin,
  input wire logic lineSyncIn,
  input wire logic frameSyncIn,
  input wire logic address_select_strap,
  // From the sync separator on this clock
  input wire logic separatedFrameSync,
  // Configuration held outside this block
  input wire logic [7:0] clampDelay,
  input wire logic [7:0] clampDuration,
  input wire logic [7:0] lineSyncOutWidth,
  input wire logic lineSyncOutActiveHigh,
  input wire logic frameSyncSeparatedSel,
  // Control outputs
  output logic useExternalSampleClock,
  output logic pllHold,
  output logic powerDown,
  output logic clampActive,
  output logic regenerated_line_sync_out,
  output logic frame_sync_out,
  output logic addressLsb
);
  typedef struct packed {
    logic [capture_pin_pkg::PIN_COUNT-1:0] sync1;
    logic [capture_pin_pkg::PIN_COUNT-1:0] sync2;
    logic [7:0] clockSource;
    logic [7:0] lineSyncCfg;
    logic [7:0] frameCfgA;
    logic [7:0] frameWidth;
    logic [7:0] clampHoldPol;
    logic [7:0] powerDownCfg;
    logic [7:0] rdData;
    logic lineActPrev;
    logic frameActPrev;
    capture_pin_pkg::clamp_phase_t clampPhase;
    logic [7:0] clampCnt;
    logic [7:0] lineOutCnt;
    logic lineOutActive;
    logic [7:0] frameOutCnt;
    logic frameOutActive;
    logic strapTaken;
    logic addrLsb;
    logic extClkSel;
    logic hold;
    logic pwrDown;
    logic clampOut;
    logic lineOut;
    logic frameOut;
  } ctrl_t;

  ctrl_t c_r;
  ctrl_t c_nxt;

  logic clampPinActive;
  logic coastActive;
  logic lineActive;
  logic frameActive;

  ////////////////////////////////////////////////////////////////////////
  // Active-level resolution

  sense_resolve clamp_sense (
    .clk(clk),
    .rst_n(rst_n),
    .level(c_r.sync2[capture_pin_pkg::PIN_CLAMP]),
    .polField(c_r.clampHoldPol[capture_pin_pkg::CLAMP_HOLD_POL_LSB +: 2]),
    .active(clampPinActive)
  );

  sense_resolve coast_sense (
    .clk(clk),
    .rst_n(rst_n),
    .level(c_r.sync2[capture_pin_pkg::PIN_COAST]),
    .polField(c_r.clampHoldPol[capture_pin_pkg::CLAMP_HOLD_POL_LSB +: 2]),
    .active(coastActive)
  );

  sense_resolve line_sense (
    .clk(clk),
    .rst_n(rst_n),
    .level(c_r.sync2[capture_pin_pkg::PIN_LINE]),
    .polField(c_r.lineSyncCfg[capture_pin_pkg::LINE_POL_LSB +: 2]),
    .active(lineActive)
  );

  sense_resolve frame_sense (
    .clk(clk),
    .rst_n(rst_n),
    .level(c_r.sync2[capture_pin_pkg::PIN_FRAME]),
    .polField(c_r.frameCfgA[capture_pin_pkg::FRAME_POL_LSB +: 2]),
    .active(frameActive)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic lineLead;
    logic lineTrail;
    logic frameLead;
    logic frameTrail;
    logic frameSrc;
    logic frameSrcPrev;
    logic pinPdActive;
    lineLead = 1'b0;
    lineTrail = 1'b0;
    frameLead = 1'b0;
    frameTrail = 1'b0;
    frameSrc = 1'b0;
    frameSrcPrev = 1'b0;
    pinPdActive = 1'b0;
    c_nxt = c_r;
    c_nxt.sync1 = {address_select_strap, frameSyncIn, lineSyncIn,
                   power_down_pin, extClockCoastPin, clampPin};
    c_nxt.sync2 = c_r.sync1;

    // Register writes and reads
    if (regWe) begin
      unique case (regAddr)
        capture_pin_pkg::OFF_CLOCK_SOURCE: c_nxt.clockSource = regWrData;
        capture_pin_pkg::OFF_LINE_SYNC_CFG: c_nxt.lineSyncCfg = regWrData;
        capture_pin_pkg::OFF_FRAME_SYNC_CFG_A: c_nxt.frameCfgA = regWrData;
        capture_pin_pkg::OFF_FRAME_SYNC_WIDTH: c_nxt.frameWidth = regWrData;
        capture_pin_pkg::OFF_CLAMP_HOLD_POL: c_nxt.clampHoldPol = regWrData;
        capture_pin_pkg::OFF_POWER_DOWN: c_nxt.powerDownCfg = regWrData;
        default: ;
      endcase
    end
    unique case (regAddr)
      capture_pin_pkg::OFF_CLOCK_SOURCE: c_nxt.rdData = c_r.clockSource;
      capture_pin_pkg::OFF_LINE_SYNC_CFG: c_nxt.rdData = c_r.lineSyncCfg;
      capture_pin_pkg::OFF_FRAME_SYNC_CFG_A: c_nxt.rdData = c_r.frameCfgA;
      capture_pin_pkg::OFF_FRAME_SYNC_WIDTH: c_nxt.rdData = c_r.frameWidth;
      capture_pin_pkg::OFF_CLAMP_HOLD_POL: c_nxt.rdData = c_r.clampHoldPol;
      capture_pin_pkg::OFF_POWER_DOWN: c_nxt.rdData = c_r.powerDownCfg;
      default: c_nxt.rdData = capture_pin_pkg::RD_UNMAPPED;
    endcase

    // Line sync edges in active sense
    c_nxt.lineActPrev = lineActive;
    lineLead = lineActive && !c_r.lineActPrev;
    lineTrail = !lineActive && c_r.lineActPrev;

    // Clock source and hold share one pin but are decoded independently
    c_nxt.extClkSel = c_r.clockSource[capture_pin_pkg::EXT_CLK_SEL_BIT];
    c_nxt.hold = coastActive;

    // Power-down
    pinPdActive = c_r.sync2[capture_pin_pkg::PIN_POWER_DOWN] ==
                  c_r.powerDownCfg[capture_pin_pkg::PD_PIN_POL_BIT];
    c_nxt.pwrDown = c_r.powerDownCfg[capture_pin_pkg::PD_MANUAL_BIT] &&
                    (c_r.powerDownCfg[capture_pin_pkg::PD_CMD_BIT] || pinPdActive);

    // Internal clamp window from the trailing edge
    unique case (c_r.clampPhase)
      capture_pin_pkg::CLAMP_IDLE: begin
        if (lineTrail) begin
          c_nxt.clampPhase = capture_pin_pkg::CLAMP_DELAY;
          c_nxt.clampCnt = clampDelay;
        end
      end
      capture_pin_pkg::CLAMP_DELAY: begin
        if (c_r.clampCnt == capture_pin_pkg::CNT_ZERO) begin
          c_nxt.clampPhase = capture_pin_pkg::CLAMP_WINDOW;
          c_nxt.clampCnt = clampDuration;
        end else begin
          c_nxt.clampCnt = c_r.clampCnt - capture_pin_pkg::CNT_ONE;
        end
      end
      capture_pin_pkg::CLAMP_WINDOW: begin
        if (c_r.clampCnt <= capture_pin_pkg::CNT_ONE) begin
          c_nxt.clampPhase = capture_pin_pkg::CLAMP_IDLE;
        end
        c_nxt.clampCnt = c_r.clampCnt - capture_pin_pkg::CNT_ONE;
      end
      default: c_nxt.clampPhase = capture_pin_pkg::CLAMP_IDLE;
    endcase
    if (c_r.clampHoldPol[capture_pin_pkg::CLAMP_EXT_BIT]) begin
      c_nxt.clampOut = clampPinActive;
    end else begin
      c_nxt.clampOut = c_r.clampPhase == capture_pin_pkg::CLAMP_WINDOW &&
                       c_r.clampCnt != capture_pin_pkg::CNT_ZERO;
    end

    // Regenerated line sync, starting on the leading edge
    if (lineLead && lineSyncOutWidth != capture_pin_pkg::CNT_ZERO) begin
      c_nxt.lineOutActive = 1'b1;
      c_nxt.lineOutCnt = lineSyncOutWidth;
    end else if (c_r.lineOutActive) begin
      c_nxt.lineOutCnt = c_r.lineOutCnt - capture_pin_pkg::CNT_ONE;
      c_nxt.lineOutActive = c_r.lineOutCnt != capture_pin_pkg::CNT_ONE;
    end
    c_nxt.lineOut = c_nxt.lineOutActive == lineSyncOutActiveHigh;

    // Frame sync output: source, width and polarity
    c_nxt.frameActPrev = frameSyncSeparatedSel ? separatedFrameSync : frameActive;
    frameSrc = c_nxt.frameActPrev;
    frameSrcPrev = c_r.frameActPrev;
    frameLead = frameSrc && !frameSrcPrev;
    frameTrail = !frameSrc && frameSrcPrev;
    if (c_r.frameCfgA[capture_pin_pkg::FRAME_WIDTH_OVR_BIT]) begin
      // Width counted in lines from the source's leading edge
      if (frameLead && c_r.frameWidth != capture_pin_pkg::CNT_ZERO) begin
        c_nxt.frameOutActive = 1'b1;
        c_nxt.frameOutCnt = c_r.frameWidth;
      end else if (c_r.frameOutActive && lineLead) begin
        c_nxt.frameOutCnt = c_r.frameOutCnt - capture_pin_pkg::CNT_ONE;
        c_nxt.frameOutActive = c_r.frameOutCnt != capture_pin_pkg::CNT_ONE;
      end
    end else begin
      if (frameLead) begin
        c_nxt.frameOutActive = 1'b1;
      end else if (frameTrail) begin
        c_nxt.frameOutActive = 1'b0;
      end
    end
    c_nxt.frameOut = c_nxt.frameOutActive ==
                     c_r.frameCfgA[capture_pin_pkg::FRAME_OUT_POL_BIT];

    // Strap taken at the first edge after release, then frozen
    if (!c_r.strapTaken) begin
      c_nxt.addrLsb = c_r.sync2[capture_pin_pkg::PIN_STRAP];
      c_nxt.strapTaken = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c_r <= '0;
      // Synchroniser runs through reset so the strap has settled at release
      c_r.sync1 <= c_nxt.sync1;
      c_r.sync2 <= c_nxt.sync2;
      c_r.clockSource <= capture_pin_pkg::RST_CLOCK_SOURCE;
      c_r.lineSyncCfg <= capture_pin_pkg::RST_LINE_SYNC_CFG;
      c_r.frameCfgA <= capture_pin_pkg::RST_FRAME_SYNC_CFG_A;
      c_r.frameWidth <= capture_pin_pkg::RST_FRAME_SYNC_WIDTH;
      c_r.clampHoldPol <= capture_pin_pkg::RST_CLAMP_HOLD_POL;
      c_r.powerDownCfg <= capture_pin_pkg::RST_POWER_DOWN;
      c_r.clampPhase <= capture_pin_pkg::CLAMP_IDLE;
      c_r.lineOut <= 1'b1;
      c_r.frameOut <= 1'b1;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign regRdData = c_r.rdData;
  assign useExternalSampleClock = c_r.extClkSel;
  assign pllHold = c_r.hold;
  assign powerDown = c_r.pwrDown;
  assign clampActive = c_r.clampOut;
  assign regenerated_line_sync_out = c_r.lineOut;
  assign frame_sync_out = c_r.frameOut;
  assign addressLsb = c_r.addrLsb;
endmodule

/* design/capture_pin_pkg.sv */
// Constants for the capture pin control block
package capture_pin_pkg;
  // Register offsets
  localparam logic [7:0] OFF_CLOCK_SOURCE = 8'h03;
  localparam logic [7:0] OFF_LINE_SYNC_CFG = 8'h12;
  localparam logic [7:0] OFF_FRAME_SYNC_CFG_A = 8'h14;
  localparam logic [7:0] OFF_FRAME_SYNC_WIDTH = 8'h15;
  localparam logic [7:0] OFF_CLAMP_HOLD_POL = 8'h18;
  localparam logic [7:0] OFF_POWER_DOWN = 8'h1e;

  // Reset values
  localparam logic [7:0] RST_CLOCK_SOURCE = 8'h00;
  localparam logic [7:0] RST_LINE_SYNC_CFG = 8'h00;
  localparam logic [7:0] RST_FRAME_SYNC_CFG_A = 8'h00;
  localparam logic [7:0] RST_FRAME_SYNC_WIDTH = 8'h00;
  localparam logic [7:0] RST_CLAMP_HOLD_POL = 8'hc0;
  localparam logic [7:0] RST_POWER_DOWN = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Field positions
  localparam int EXT_CLK_SEL_BIT = 2;
  localparam int LINE_POL_LSB = 4;
  localparam int FRAME_POL_LSB = 4;
  localparam int FRAME_WIDTH_OVR_BIT = 3;
  localparam int FRAME_OUT_POL_BIT = 1;
  localparam int CLAMP_EXT_BIT = 4;
  localparam int CLAMP_HOLD_POL_LSB = 6;
  localparam int PD_MANUAL_BIT = 4;
  localparam int PD_CMD_BIT = 3;
  localparam int PD_PIN_POL_BIT = 2;

  // Polarity field: bit 1 forces manual, bit 0 is the active level
  localparam int POL_MANUAL_BIT = 1;
  localparam int POL_LEVEL_BIT = 0;

  // Automatic sense detector balance counter
  localparam int DETECT_BITS = 8;
  localparam logic [DETECT_BITS-1:0] DETECT_MID = 8'h80;
  localparam logic [DETECT_BITS-1:0] DETECT_MAX = 8'hff;
  localparam logic [DETECT_BITS-1:0] DETECT_MIN = 8'h00;

  // Synchronised pin vector indices
  localparam int PIN_CLAMP = 0;
  localparam int PIN_COAST = 1;
  localparam int PIN_POWER_DOWN = 2;
  localparam int PIN_LINE = 3;
  localparam int PIN_FRAME = 4;
  localparam int PIN_STRAP = 5;
  localparam int PIN_COUNT = 6;

  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;

  typedef enum logic [1:0] {CLAMP_IDLE, CLAMP_DELAY, CLAMP_WINDOW} clamp_phase_t;
endpackage

/* design/sense_resolve.sv */
// Active-level resolver: automatic detection or manual polarity
`timescale 1ns/1ps
module sense_resolve (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised pin level and polarity field
  input wire logic level,
  input wire logic [1:0] polField,
  // Level is in its active state
  output logic active
);
  typedef struct packed {
    logic [capture_pin_pkg::DETECT_BITS-1:0] balance;
    logic active;
  } sense_t;

  sense_t s_r;
  sense_t s_nxt;

  always_comb begin
    logic autoHigh;
    logic activeHigh;
    autoHigh = 1'b0;
    activeHigh = 1'b0;
    s_nxt = s_r;
    // Sync pulses are short, so the rarer level is the active one
    if (level && s_r.balance != capture_pin_pkg::DETECT_MAX) begin
      s_nxt.balance = s_r.balance + capture_pin_pkg::CNT_ONE;
    end else if (!level && s_r.balance != capture_pin_pkg::DETECT_MIN) begin
      s_nxt.balance = s_r.balance - capture_pin_pkg::CNT_ONE;
    end
    autoHigh = s_r.balance < capture_pin_pkg::DETECT_MID;
    activeHigh = polField[capture_pin_pkg::POL_MANUAL_BIT] ?
                 polField[capture_pin_pkg::POL_LEVEL_BIT] : autoHigh;
    // Undecided balance just after reset reports idle, so no false edge follows
    s_nxt.active = (level == activeHigh) &&
                   (polField[capture_pin_pkg::POL_MANUAL_BIT] ||
                    s_r.balance != capture_pin_pkg::DETECT_MID);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '{balance: capture_pin_pkg::DETECT_MID, active: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign active = s_r.active;
endmodule

/* verification/capture_pin_chk.sv */
// Checker for the capture pin control block
`timescale 1ns/1ps
module capture_pin_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic regWe,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  // Pins and settings
  input wire logic clampPin,
  input wire logic extClockCoastPin,
  input wire logic power_down_pin,
  input wire logic lineSyncIn,
  input wire logic address_select_strap,
  input wire logic separatedFrameSync,
  input wire logic [7:0] lineSyncOutWidth,
  input wire logic lineSyncOutActiveHigh,
  input wire logic frameSyncSeparatedSel,
  // Outputs
  input wire logic useExternalSampleClock,
  input wire logic pllHold,
  input wire logic powerDown,
  input wire logic clampActive,
  input wire logic regenerated_line_sync_out,
  input wire logic frame_sync_out,
  input wire logic addressLsb
);
  logic [7:0] s03, s12, s14, s18, s1e;
  logic [3:0] quiet, up;
  // Shadow copies, plus cycles since reset and since the last write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {s03, s12, s14, s1e} <= 32'h0;
      s18 <= 8'hc0;
      quiet <= 4'h0;
      up <= 4'h0;
    end else begin
      up <= (up == 4'hf) ? up : up + 4'h1;
      quiet <= regWe ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
      if (regWe && regAddr == 8'h03) s03 <= regWrData;
      if (regWe && regAddr == 8'h12) s12 <= regWrData;
      if (regWe && regAddr == 8'h14) s14 <= regWrData;
      if (regWe && regAddr == 8'h18) s18 <= regWrData;
      if (regWe && regAddr == 8'h1e) s1e <= regWrData;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  property p_ext_clk;
    quiet >= 4'h3 |-> useExternalSampleClock == s03[2];
  endproperty
  a_ext_clk: assert property (p_ext_clk)
    else $error("sample clock select wrong");
  property p_pd;
    quiet >= 4'h5 |-> powerDown == (s1e[4] & (s1e[3] | ($past(power_down_pin, 3) == s1e[2])));
  endproperty
  a_pd: assert property (p_pd)
    else $error("power-down wrong");
  property p_hold;
    quiet >= 4'h5 && s18[7] |-> pllHold == ($past(extClockCoastPin, 4) == s18[6]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold wrong");
  property p_clamp_ext;
    quiet >= 4'h5 && s18[7] && s18[4] |-> clampActive == ($past(clampPin, 4) == s18[6]);
  endproperty
  a_clamp_ext: assert property (p_clamp_ext)
    else $error("external clamp wrong");
  property p_line;
    quiet >= 4'h8 && s12[5:4] == 2'b11 && lineSyncOutActiveHigh && lineSyncOutWidth != 8'h00
      && $rose(lineSyncIn) |-> ##[3:5] regenerated_line_sync_out;
  endproperty
  a_line: assert property (p_line)
    else $error("line sync out missing");
  property p_frame;
    quiet >= 4'h2 && frameSyncSeparatedSel && !s14[3] && $rose(separatedFrameSync)
      |-> ##[1:4] frame_sync_out == s14[1];
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame sync out missing");
  property p_strap_val;
    up == 4'h8 |-> addressLsb == address_select_strap;
  endproperty
  a_strap_val: assert property (p_strap_val)
    else $error("address bit wrong");
  property p_strap_hold;
    up >= 4'h8 |-> $stable(addressLsb);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("address bit moved");
  c_hold: cover property (pllHold);
  c_clamp: cover property (clampActive && !s18[4]);
  c_frame: cover property ($rose(frame_sync_out));
endmodule

bind capture_pin_control capture_pin_chk u_chk (.clk, .rst_n, .regWe, .regAddr, .regWrData,
  .clampPin, .extClockCoastPin, .power_down_pin, .lineSyncIn, .address_select_strap,
  .separatedFrameSync, .lineSyncOutWidth, .lineSyncOutActiveHigh, .frameSyncSeparatedSel,
  .useExternalSampleClock, .pllHold, .powerDown, .clampActive, .regenerated_line_sync_out,
  .frame_sync_out, .addressLsb);

/* verification/sync_source_model.sv */
// Video source model: line and frame sync pulses on request
`timescale 1ns/1ps
module sync_source_model (
  // Clock and requests
  input wire logic clk,
  input wire logic lineGo,
  input wire logic frameGo,
  // Sync lines, active high
  output logic lineSyncIn,
  output logic frameSyncIn,
  output logic separatedFrameSync
);
  int lineCnt = 0;
  int frameCnt = 0;
  logic lineReq = 1'b0;
  logic frameReq = 1'b0;
  // Requests taken on the rising edge, lines moved on the falling one
  always @(posedge clk) begin
    lineReq <= lineGo;
    frameReq <= frameGo;
  end
  always @(negedge clk) begin
    lineCnt <= lineReq ? 6 : ((lineCnt > 0) ? lineCnt - 1 : 0);
    frameCnt <= frameReq ? 6 : ((frameCnt > 0) ? frameCnt - 1 : 0);
  end
  assign lineSyncIn = lineCnt > 0;
  assign frameSyncIn = frameCnt > 0;
  assign separatedFrameSync = frameCnt > 0;
endmodule

/* verification/tb.sv */
// Testbench for the capture pin control block
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, regWe, clampPin, extClockCoastPin, power_down_pin, address_select_strap;
  logic lineSyncOutActiveHigh, frameSyncSeparatedSel, lineGo, frameGo;
  logic lineSyncIn, frameSyncIn, separatedFrameSync, useExternalSampleClock, pllHold;
  logic powerDown, clampActive, regenerated_line_sync_out, frame_sync_out, addressLsb;
  logic [7:0] regAddr, regWrData, regRdData, clampDelay, clampDuration, lineSyncOutWidth;
  int fails = 0;
  int checked = 0;
  int nLine, nClamp, nFrame;
  logic [7:0] offs [7] = '{8'h03, 8'h12, 8'h14, 8'h15, 8'h18, 8'h1e, 8'h40};
  logic [7:0] rstv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00};

  capture_pin_control u_dut (.clk, .rst_n, .regWe, .regAddr, .regWrData, .regRdData,
    .clampPin, .extClockCoastPin, .power_down_pin, .lineSyncIn, .frameSyncIn,
    .address_select_strap, .separatedFrameSync, .clampDelay, .clampDuration,
    .lineSyncOutWidth, .lineSyncOutActiveHigh, .frameSyncSeparatedSel,
    .useExternalSampleClock, .pllHold, .powerDown, .clampActive,
    .regenerated_line_sync_out, .frame_sync_out, .addressLsb);
  sync_source_model u_src (.clk, .lineGo, .frameGo, .lineSyncIn, .frameSyncIn,
    .separatedFrameSync);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regWe = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWe = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    check(regRdData, exp);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Fires the source, then counts active cycles of the three outputs
  task automatic pulse(input logic ln, input logic fr, input logic lvlL, input logic lvlF);
    @(negedge clk);
    lineGo = ln;
    frameGo = fr;
    @(negedge clk);
    lineGo = 1'b0;
    frameGo = 1'b0;
    nLine = 0;
    nClamp = 0;
    nFrame = 0;
    repeat (40) begin
      @(negedge clk);
      nLine += int'(regenerated_line_sync_out === lvlL);
      nClamp += int'(clampActive === 1'b1);
      nFrame += int'(frame_sync_out === lvlF);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // Tests need under 1000 cycles; three times that means a hang
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    {rst_n, regWe, clampPin, extClockCoastPin, power_down_pin, lineGo, frameGo} = 7'h00;
    {regAddr, regWrData} = 16'h0000;
    address_select_strap = 1'b1;
    clampDelay = 8'h03;
    clampDuration = 8'h04;
    lineSyncOutWidth = 8'h05;
    lineSyncOutActiveHigh = 1'b1;
    frameSyncSeparatedSel = 1'b1;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++) rd(offs[i], rstv[i]);
    wr(8'h40, 8'h5a);
    rd(8'h40, 8'h00);
    check({7'h00, addressLsb}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(offs[i], offs[i] ^ 8'h5a);
      rd(offs[i], offs[i] ^ 8'h5a);
    end
    wr(8'h03, 8'h04);
    wr(8'h18, 8'hc0);
    extClockCoastPin = 1'b1;
    waitc(6);
    check({6'h00, useExternalSampleClock, pllHold}, 8'h03);
    wr(8'h03, 8'h00);
    waitc(6);
    check({6'h00, useExternalSampleClock, pllHold}, 8'h01);
    wr(8'h18, 8'h80);
    waitc(6);
    check({7'h00, pllHold}, 8'h00);
    extClockCoastPin = 1'b0;
    waitc(6);
    check({7'h00, pllHold}, 8'h01);
    for (int i = 0; i < 16; i++) begin
      wr(8'h1e, {3'h0, i[3:1], 2'h0});
      power_down_pin = i[0];
      waitc(5);
      check({7'h00, powerDown}, {7'h00, i[3] & (i[2] | (i[0] == i[1]))});
    end
    wr(8'h1e, 8'h00);
    wr(8'h18, 8'hd0);
    clampPin = 1'b1;
    waitc(6);
    check({7'h00, clampActive}, 8'h01);
    wr(8'h18, 8'h90);
    waitc(6);
    check({7'h00, clampActive}, 8'h00);
    wr(8'h18, 8'hc0);
    waitc(6);
    check({7'h00, clampActive}, 8'h00);
    clampPin = 1'b0;
    wr(8'h12, 8'h30);
    waitc(8);
    pulse(1'b1, 1'b0, 1'b1, 1'b1);
    check(8'(nLine), 8'h05);
    check(8'(nClamp), 8'h04);
    lineSyncOutActiveHigh = 1'b0;
    lineSyncOutWidth = 8'h02;
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    check(8'(nLine), 8'h02);
    lineSyncOutWidth = 8'h00;
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    check(8'(nLine), 8'h00);
    wr(8'h14, 8'h02);
    pulse(1'b0, 1'b1, 1'b1, 1'b1);
    check(8'(nFrame), 8'h06);
    wr(8'h14, 8'h00);
    pulse(1'b0, 1'b1, 1'b1, 1'b0);
    check(8'(nFrame), 8'h06);
    frameSyncSeparatedSel = 1'b0;
    wr(8'h14, 8'h32);
    pulse(1'b0, 1'b1, 1'b1, 1'b1);
    check(8'(nFrame), 8'h06);
    // Width from register: frame lead starts it, two later line leads end it
    wr(8'h15, 8'h02);
    wr(8'h14, 8'h3a);
    pulse(1'b1, 1'b1, 1'b1, 1'b1);
    check({7'h00, frame_sync_out}, 8'h01);
    pulse(1'b1, 1'b0, 1'b1, 1'b1);
    check({7'h00, frame_sync_out}, 8'h01);
    pulse(1'b1, 1'b0, 1'b1, 1'b1);
    check({7'h00, frame_sync_out}, 8'h00);
    address_select_strap = 1'b0;
    waitc(6);
    check({7'h00, addressLsb}, 8'h01);
    print_verdict();
  end
endmodule
